// File: acocr_regs.sv
/*
 Output and clock configuration register bank of a quad serial converter.
 Assumes a register port already decoded from the serial control port:
 one-cycle write strobe with address and data, combinational-address read
 answered on the next edge, all on the converter clock clk_i.
 The serial-port-mode pin level is asynchronous and is synchronised here.
*/
// What this block does
// - Clock register bit 0 resets to one; one turns duty stabilizer off.
// - Without serial port configuration, duty stabilizer stays on regardless.
// - Chop bit enables first-stage chopping of offsets and low noise.
// - Output mode bit 6 picks reduced swing; clear picks standard swing.
// - Output invert bit inverts every serialized output bit.
// - Output format bit resets to one for two's complement; zero is binary.
// - Two-bit termination field selects output driver termination resistor.
// - Output drive bit doubles frame and bit clock drive, for the clocks selected by index bits 5 and 4.
// - Termination selection overrides double drive on the clock outputs.
// - Input phase field delays sampling zero to seven input clock cycles.
// - Output phase field shifts bit clock by 60 degrees per step.
// - Serialization register selects output serialization mode.
// - Rate override takes effect only after transfer bit zero written.
// - Active rate override lowers capability, sampling rate unchanged.
// - User I/O bit zero disconnects the serial data pin pull-down.
// - All other registers take effect immediately when written.
// - Device index low four bits choose channels for per-channel writes.
`timescale 1ns/100ps
module acocr_regs
    import acocr_pkg::*;
#(
    parameter int NCH = acocr_pkg::ACOCR_NCH
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic serial_mode_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [acocr_pkg::ACOCR_AW-1:0] addr_i,
    input wire logic [acocr_pkg::ACOCR_DW-1:0] wdata_i,
    output logic [acocr_pkg::ACOCR_DW-1:0] rdata_o,
    output logic rvalid_o,
    output logic dcs_enable_o,
    output logic chop_enable_o,
    output logic reduced_swing_o,
    output logic invert_o,
    output logic twos_comp_o,
    output logic [NCH-1:0] term_sel_o,
    output logic [1:0] term_code_o,
    output logic drive_2x_fco_o,
    output logic drive_2x_dco_o,
    output logic [2:0] in_phase_o,
    output logic [3:0] out_phase_o,
    output logic [2:0] ser_mode_o,
    output logic [7:0] ser_ctrl_o,
    output logic rate_ovr_en_o,
    output logic [2:0] rate_ovr_code_o,
    output logic sdio_pulldown_en_o
);
    import acocr_pkg::*;

    // ======================================================================
    // Write decode
    logic mode_sync;
    logic [7:0] idx_q, clk_q, enh_q, om_q, oa_q, ph_q, ser_q, ovr_q, uio_q;
    logic we_idx, we_clk, we_enh, we_om, we_oa, we_ph, we_ser, we_ovr, we_uio;
    logic we_xfer;

    function automatic logic hit(input logic [12:0] a, input logic [12:0] r);
        hit = (a == r);
    endfunction

    assign we_idx = wr_i && hit(addr_i, ADDR_DEVICE_INDEX);
    assign we_clk = wr_i && hit(addr_i, ADDR_CLOCK_COND);
    assign we_enh = wr_i && hit(addr_i, ADDR_ENH_CTRL);
    assign we_om = wr_i && hit(addr_i, ADDR_OUTPUT_MODE);
    assign we_oa = wr_i && hit(addr_i, ADDR_OUTPUT_ADJUST);
    assign we_ph = wr_i && hit(addr_i, ADDR_OUTPUT_PHASE);
    assign we_ser = wr_i && hit(addr_i, ADDR_SERIAL_CTRL);
    assign we_ovr = wr_i && hit(addr_i, ADDR_RATE_OVERRIDE);
    assign we_uio = wr_i && hit(addr_i, ADDR_USER_IO_TWO);
    assign we_xfer = wr_i && hit(addr_i, ADDR_TRANSFER) &&
                     wdata_i[BIT_TRANSFER];

    acocr_sync u_mode_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .d_i(serial_mode_i),
        .q_o(mode_sync)
    );

    // ======================================================================
    // Register storage
    acocr_field #(.RST(RST_DEVICE_INDEX), .MASK(MASK_DEVICE_INDEX)) u_idx (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .we_i(we_idx),
        .wdata_i(wdata_i), .q_o(idx_q)
    );
    acocr_field #(.RST(RST_CLOCK_COND), .MASK(MASK_CLOCK_COND)) u_clk (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .we_i(we_clk),
        .wdata_i(wdata_i), .q_o(clk_q)
    );
    acocr_field #(.RST(RST_ENH_CTRL), .MASK(MASK_ENH_CTRL)) u_enh (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .we_i(we_enh),
        .wdata_i(wdata_i), .q_o(enh_q)
    );
    acocr_field #(.RST(RST_OUTPUT_MODE), .MASK(MASK_OUTPUT_MODE)) u_om (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .we_i(we_om),
        .wdata_i(wdata_i), .q_o(om_q)
    );
    acocr_field #(.RST(RST_OUTPUT_ADJUST), .MASK(MASK_OUTPUT_ADJUST)) u_oa (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .we_i(we_oa),
        .wdata_i(wdata_i), .q_o(oa_q)
    );
    acocr_field #(.RST(RST_SERIAL_CTRL), .MASK(MASK_SERIAL_CTRL)) u_ser (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .we_i(we_ser),
        .wdata_i(wdata_i), .q_o(ser_q)
    );
    acocr_field #(.RST(RST_RATE_OVERRIDE), .MASK(MASK_RATE_OVERRIDE)) u_ovr (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .we_i(we_ovr),
        .wdata_i(wdata_i), .q_o(ovr_q)
    );
    acocr_field #(.RST(RST_USER_IO_TWO), .MASK(MASK_USER_IO_TWO)) u_uio (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .we_i(we_uio),
        .wdata_i(wdata_i), .q_o(uio_q)
    );

    // Output clock phase codes above the table top are clamped, since the
    // phase generator has no setting for them
    logic [7:0] ph_wr;
    always_comb begin
        ph_wr = wdata_i & MASK_OUTPUT_PHASE;
        if (ph_wr[OUT_PHASE_LSB +: 4] > OUT_PHASE_MAX) begin
            ph_wr[OUT_PHASE_LSB +: 4] = OUT_PHASE_MAX;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ph_q <= RST_OUTPUT_PHASE;
        end else if (we_ph) begin
            ph_q <= ph_wr;
        end
    end

    // ======================================================================
    // Immediate settings
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dcs_enable_o <= 1'b1;
        end else begin
            dcs_enable_o <= !mode_sync || !clk_q[BIT_DCS_OFF];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chop_enable_o <= 1'b0;
            reduced_swing_o <= 1'b0;
            invert_o <= 1'b0;
            twos_comp_o <= 1'b1;
        end else begin
            chop_enable_o <= enh_q[BIT_CHOP];
            reduced_swing_o <= om_q[BIT_REDUCED_SWING];
            invert_o <= om_q[BIT_INVERT];
            twos_comp_o <= om_q[BIT_TWOS_COMP];
        end
    end

    // Per-channel settings land only on channels chosen by the index
    logic [NCH-1:0] ch_sel;
    logic fco_sel, dco_sel;
    logic [1:0] term_fld;
    assign ch_sel = idx_q[CH_SEL_LSB +: NCH];
    assign dco_sel = idx_q[CLK_SEL_LSB];
    assign fco_sel = idx_q[CLK_SEL_LSB + 1];
    assign term_fld = oa_q[TERM_LSB +: 2];

    logic [NCH-1:0] term_sel_r;
    logic drive_fco_r, drive_dco_r;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            term_sel_r <= '0;
            drive_fco_r <= 1'b0;
            drive_dco_r <= 1'b0;
        end else if (we_oa) begin
            term_sel_r <= ch_sel;
            // Unselected clock outputs keep the strength they already had
            if (fco_sel) begin
                drive_fco_r <= wdata_i[BIT_DRIVE_2X];
            end
            if (dco_sel) begin
                drive_dco_r <= wdata_i[BIT_DRIVE_2X];
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            term_sel_o <= '0;
            term_code_o <= TERM_NONE;
            drive_2x_fco_o <= 1'b0;
            drive_2x_dco_o <= 1'b0;
        end else begin
            term_sel_o <= term_sel_r;
            term_code_o <= term_fld;
            drive_2x_fco_o <= drive_fco_r && (term_fld == TERM_NONE);
            drive_2x_dco_o <= drive_dco_r && (term_fld == TERM_NONE);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            in_phase_o <= RST_OUTPUT_PHASE[IN_PHASE_LSB +: 3];
            out_phase_o <= RST_OUTPUT_PHASE[OUT_PHASE_LSB +: 4];
            ser_mode_o <= RST_SERIAL_CTRL[SER_MODE_LSB +: 3];
            ser_ctrl_o <= RST_SERIAL_CTRL;
            sdio_pulldown_en_o <= 1'b1;
        end else begin
            // Divider bound on this field is left to software
            in_phase_o <= ph_q[IN_PHASE_LSB +: 3];
            out_phase_o <= ph_q[OUT_PHASE_LSB +: 4];
            ser_mode_o <= ser_q[SER_MODE_LSB +: 3];
            ser_ctrl_o <= ser_q;
            sdio_pulldown_en_o <= !uio_q[BIT_PULLDOWN_OFF];
        end
    end

    // ======================================================================
    // Rate override, applied on transfer only
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rate_ovr_en_o <= 1'b0;
            rate_ovr_code_o <= 3'h0;
        end else if (we_xfer) begin
            // Capability limit only; the sample clock path never sees it
            rate_ovr_en_o <= ovr_q[BIT_OVR_EN];
            rate_ovr_code_o <= ovr_q[2:0];
        end
    end

    // ======================================================================
    // Read port
    logic [7:0] rd_mux;
    always_comb begin
        if (hit(addr_i, ADDR_DEVICE_INDEX)) begin
            rd_mux = idx_q;
        end else if (hit(addr_i, ADDR_CLOCK_COND)) begin
            rd_mux = clk_q;
        end else if (hit(addr_i, ADDR_ENH_CTRL)) begin
            rd_mux = enh_q;
        end else if (hit(addr_i, ADDR_OUTPUT_MODE)) begin
            rd_mux = om_q | FIXED_OUTPUT_MODE;
        end else if (hit(addr_i, ADDR_OUTPUT_ADJUST)) begin
            rd_mux = oa_q;
        end else if (hit(addr_i, ADDR_OUTPUT_PHASE)) begin
            rd_mux = ph_q;
        end else if (hit(addr_i, ADDR_SERIAL_CTRL)) begin
            rd_mux = ser_q;
        end else if (hit(addr_i, ADDR_RATE_OVERRIDE)) begin
            rd_mux = ovr_q;
        end else if (hit(addr_i, ADDR_USER_IO_TWO)) begin
            rd_mux = uio_q;
        end else begin
            rd_mux = 8'h00;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_i;
            if (rd_i) begin
                rdata_o <= rd_mux;
            end
        end
    end
endmodule

// File: acocr_pkg.sv
/*
 Package for the converter output and clock configuration register bank:
 register addresses, field positions, reset values and mode encodings.
 Assumes a 13-bit register address and 8-bit register data.
*/
package acocr_pkg;
    // ======================================================================
    // Bus shape
    localparam int ACOCR_AW = 13;
    localparam int ACOCR_DW = 8;
    localparam int ACOCR_NCH = 4;

    // ======================================================================
    // Register addresses
    localparam logic [12:0] ADDR_DEVICE_INDEX = 13'h0005;
    localparam logic [12:0] ADDR_CLOCK_COND = 13'h0009;
    localparam logic [12:0] ADDR_ENH_CTRL = 13'h000C;
    localparam logic [12:0] ADDR_OUTPUT_MODE = 13'h0014;
    localparam logic [12:0] ADDR_OUTPUT_ADJUST = 13'h0015;
    localparam logic [12:0] ADDR_OUTPUT_PHASE = 13'h0016;
    localparam logic [12:0] ADDR_SERIAL_CTRL = 13'h0021;
    localparam logic [12:0] ADDR_TRANSFER = 13'h00FF;
    localparam logic [12:0] ADDR_RATE_OVERRIDE = 13'h0100;
    localparam logic [12:0] ADDR_USER_IO_TWO = 13'h0101;

    // ======================================================================
    // Writable bit masks; open bits read zero, except output mode bit 1
    localparam logic [7:0] MASK_DEVICE_INDEX = 8'h3F;
    localparam logic [7:0] MASK_CLOCK_COND = 8'h01;
    localparam logic [7:0] MASK_ENH_CTRL = 8'h04;
    localparam logic [7:0] MASK_OUTPUT_MODE = 8'h45;
    localparam logic [7:0] MASK_OUTPUT_ADJUST = 8'h31;
    localparam logic [7:0] MASK_OUTPUT_PHASE = 8'h7F;
    localparam logic [7:0] MASK_SERIAL_CTRL = 8'hF7;
    localparam logic [7:0] MASK_RATE_OVERRIDE = 8'h47;
    localparam logic [7:0] MASK_USER_IO_TWO = 8'h01;
    // Output mode bit 1 reads as one
    localparam logic [7:0] FIXED_OUTPUT_MODE = 8'h02;

    // ======================================================================
    // Reset values
    localparam logic [7:0] RST_DEVICE_INDEX = 8'h3F;
    localparam logic [7:0] RST_CLOCK_COND = 8'h01;
    localparam logic [7:0] RST_ENH_CTRL = 8'h00;
    localparam logic [7:0] RST_OUTPUT_MODE = 8'h01;
    localparam logic [7:0] RST_OUTPUT_ADJUST = 8'h00;
    localparam logic [7:0] RST_OUTPUT_PHASE = 8'h03;
    localparam logic [7:0] RST_SERIAL_CTRL = 8'h30;
    localparam logic [7:0] RST_RATE_OVERRIDE = 8'h00;
    localparam logic [7:0] RST_USER_IO_TWO = 8'h00;

    // ======================================================================
    // Field positions
    localparam int BIT_DCS_OFF = 0;
    localparam int BIT_CHOP = 2;
    localparam int BIT_REDUCED_SWING = 6;
    localparam int BIT_INVERT = 2;
    localparam int BIT_TWOS_COMP = 0;
    localparam int TERM_LSB = 4;
    localparam int BIT_DRIVE_2X = 0;
    localparam int IN_PHASE_LSB = 4;
    localparam int OUT_PHASE_LSB = 0;
    localparam int BIT_TRANSFER = 0;
    localparam int BIT_OVR_EN = 6;
    localparam int BIT_PULLDOWN_OFF = 0;
    localparam int CH_SEL_LSB = 0;
    localparam int CLK_SEL_LSB = 4;
    localparam int SER_MODE_LSB = 4;

    // ======================================================================
    // Encodings
    localparam logic [1:0] TERM_NONE = 2'h0;
    localparam logic [3:0] OUT_PHASE_MAX = 4'hB;

    typedef enum logic [2:0] {
        ACOCR_SDR_TWO_BIT = 3'b000,
        ACOCR_SDR_TWO_BYTE = 3'b001,
        ACOCR_DDR_TWO_BIT = 3'b010,
        ACOCR_DDR_TWO_BYTE = 3'b011,
        ACOCR_DDR_ONE_WORD = 3'b100
    } acocr_ser_e;
endpackage

// File: acocr_sync.sv
/*
 Two-stage synchroniser for one level signal.
 Assumes the input is asynchronous to clk_i.
*/
`timescale 1ns/100ps
module acocr_sync (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_r;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule

// File: acocr_field.sv
/*
 One masked 8-bit configuration register with write strobe.
 Assumes the write strobe and data come from the clk_i domain.
*/
`timescale 1ns/100ps
module acocr_field #(
    parameter logic [7:0] RST = 8'h00,
    parameter logic [7:0] MASK = 8'hFF
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic we_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] q_o
);
    // Open bits never store, so they read zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q_o <= RST & MASK;
        end else if (we_i) begin
            q_o <= wdata_i & MASK;
        end
    end
endmodule

// File: acocr_regs_assertions.sv
/*
 Checker for the output and clock configuration register bank.
 Sees only the bank's ports; bound onto every instance of the bank.
*/
`timescale 1ns/100ps
module acocr_regs_assertions
    import acocr_pkg::*;
#(
    parameter int NCH = 4
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic serial_mode_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [12:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic dcs_enable_o,
    input wire logic chop_enable_o,
    input wire logic reduced_swing_o,
    input wire logic invert_o,
    input wire logic twos_comp_o,
    input wire logic [NCH-1:0] term_sel_o,
    input wire logic [1:0] term_code_o,
    input wire logic drive_2x_fco_o,
    input wire logic drive_2x_dco_o,
    input wire logic [2:0] in_phase_o,
    input wire logic [3:0] out_phase_o,
    input wire logic [2:0] ser_mode_o,
    input wire logic [7:0] ser_ctrl_o,
    input wire logic rate_ovr_en_o,
    input wire logic [2:0] rate_ovr_code_o,
    input wire logic sdio_pulldown_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // ======================================================================
    // Write data two edges back, when a write reaches the settings
    logic [7:0] w1_r, w2_r;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            w1_r <= 8'h00;
            w2_r <= 8'h00;
        end else begin
            w1_r <= wdata_i;
            w2_r <= w1_r;
        end
    end

    // ======================================================================
    // Settings
    a_dcs_bit_follows: assert property (
        serial_mode_i [*4] ##0 (wr_i && addr_i == ADDR_CLOCK_COND)
        |-> ##2 dcs_enable_o == !w2_r[BIT_DCS_OFF])
        else $error("stabilizer does not follow clock bit");
    a_dcs_forced_on: assert property (
        (!serial_mode_i) [*3] |=> dcs_enable_o)
        else $error("stabilizer off without serial mode");
    a_chop_follows: assert property (
        wr_i && addr_i == ADDR_ENH_CTRL
        |-> ##2 chop_enable_o == w2_r[BIT_CHOP])
        else $error("chop wrong");
    a_mode_follows: assert property (
        wr_i && addr_i == ADDR_OUTPUT_MODE
        |-> ##2 {reduced_swing_o, invert_o, twos_comp_o} ==
        {w2_r[BIT_REDUCED_SWING], w2_r[BIT_INVERT], w2_r[BIT_TWOS_COMP]})
        else $error("output mode wrong");
    a_phase_follows: assert property (
        wr_i && addr_i == ADDR_OUTPUT_PHASE
        |-> ##2 in_phase_o == w2_r[6:4] && out_phase_o ==
        (w2_r[3:0] > OUT_PHASE_MAX ? OUT_PHASE_MAX : w2_r[3:0]))
        else $error("phase wrong");
    a_serial_follows: assert property (
        wr_i && addr_i == ADDR_SERIAL_CTRL
        |-> ##2 ser_ctrl_o == (w2_r & MASK_SERIAL_CTRL) &&
        ser_mode_o == w2_r[6:4])
        else $error("serialization wrong");
    // The applied override moves on the edge after the transfer write
    a_override_held: assert property (
        !(wr_i && addr_i == ADDR_TRANSFER && wdata_i[BIT_TRANSFER])
        |-> ##1 $stable({rate_ovr_en_o, rate_ovr_code_o}))
        else $error("override moved without transfer");
    a_pulldown_follows: assert property (
        wr_i && addr_i == ADDR_USER_IO_TWO
        |-> ##2 sdio_pulldown_en_o == !w2_r[BIT_PULLDOWN_OFF])
        else $error("pull-down wrong");
    a_unmapped_zero: assert property (
        rd_i && addr_i == 13'h000A |=> rvalid_o && rdata_o == 8'h00)
        else $error("unmapped read wrong");
    a_term_over_drive: assert property (
        (term_code_o != TERM_NONE) [*3]
        |-> !drive_2x_fco_o && !drive_2x_dco_o)
        else $error("drive with term");
endmodule

bind acocr_regs acocr_regs_assertions #(.NCH(NCH)) u_chk (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .serial_mode_i(serial_mode_i), .wr_i(wr_i),
    .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .dcs_enable_o(dcs_enable_o),
    .chop_enable_o(chop_enable_o), .reduced_swing_o(reduced_swing_o),
    .invert_o(invert_o), .twos_comp_o(twos_comp_o), .term_sel_o(term_sel_o),
    .term_code_o(term_code_o), .drive_2x_fco_o(drive_2x_fco_o),
    .drive_2x_dco_o(drive_2x_dco_o), .in_phase_o(in_phase_o),
    .out_phase_o(out_phase_o), .ser_mode_o(ser_mode_o),
    .ser_ctrl_o(ser_ctrl_o), .rate_ovr_en_o(rate_ovr_en_o),
    .rate_ovr_code_o(rate_ovr_code_o),
    .sdio_pulldown_en_o(sdio_pulldown_en_o));

// File: acocr_regs_tb.sv
/*
 Self-checking bench for the output and clock configuration register bank.
 Assumes the bank's package; the bench drives the register port itself.
*/
`timescale 1ns/100ps
module acocr_regs_tb;
    import acocr_pkg::*;
    localparam int NCH = 4;
    localparam logic [12:0] RA [9] = '{ADDR_DEVICE_INDEX, ADDR_CLOCK_COND,
        ADDR_ENH_CTRL, ADDR_OUTPUT_MODE, ADDR_OUTPUT_ADJUST, ADDR_OUTPUT_PHASE,
        ADDR_SERIAL_CTRL, ADDR_RATE_OVERRIDE, ADDR_USER_IO_TWO};
    localparam logic [7:0] RM [9] = '{MASK_DEVICE_INDEX, MASK_CLOCK_COND,
        MASK_ENH_CTRL, MASK_OUTPUT_MODE, MASK_OUTPUT_ADJUST, MASK_OUTPUT_PHASE,
        MASK_SERIAL_CTRL, MASK_RATE_OVERRIDE, MASK_USER_IO_TWO};
    localparam logic [7:0] RR [9] = '{RST_DEVICE_INDEX, RST_CLOCK_COND,
        RST_ENH_CTRL, RST_OUTPUT_MODE, RST_OUTPUT_ADJUST, RST_OUTPUT_PHASE,
        RST_SERIAL_CTRL, RST_RATE_OVERRIDE, RST_USER_IO_TWO};
    logic clk_i = 1'b0, arst_n_i = 1'b0, serial_mode_i = 1'b0;
    logic wr_i = 1'b0, rd_i = 1'b0;
    logic [12:0] addr_i = 13'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o, ser_ctrl_o, w;
    logic rvalid_o, dcs_enable_o, chop_enable_o, reduced_swing_o, invert_o;
    logic twos_comp_o, drive_2x_fco_o, drive_2x_dco_o, rate_ovr_en_o;
    logic sdio_pulldown_en_o;
    logic [NCH-1:0] term_sel_o;
    logic [1:0] term_code_o;
    logic [2:0] in_phase_o, ser_mode_o, rate_ovr_code_o;
    logic [3:0] out_phase_o, ov;
    logic [7:0] exp_q [$];
    int mismatches = 0, samples_checked = 0, i;
    integer seed = 50;
    wire [7:0] rst_v = {dcs_enable_o, twos_comp_o, sdio_pulldown_en_o, 5'h00};
    wire [7:0] md_v = {reduced_swing_o, invert_o, twos_comp_o, 5'h00};
    wire [7:0] ph_v = {1'b0, in_phase_o, out_phase_o};
    wire [7:0] ovr_v = {4'h0, rate_ovr_en_o, rate_ovr_code_o};
    wire [7:0] drv_v = {term_sel_o, term_code_o, drive_2x_fco_o,
        drive_2x_dco_o};

    acocr_regs #(.NCH(NCH)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .serial_mode_i(serial_mode_i), .wr_i(wr_i), .rd_i(rd_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .dcs_enable_o(dcs_enable_o),
        .chop_enable_o(chop_enable_o), .reduced_swing_o(reduced_swing_o),
        .invert_o(invert_o), .twos_comp_o(twos_comp_o),
        .term_sel_o(term_sel_o), .term_code_o(term_code_o),
        .drive_2x_fco_o(drive_2x_fco_o), .drive_2x_dco_o(drive_2x_dco_o),
        .in_phase_o(in_phase_o), .out_phase_o(out_phase_o),
        .ser_mode_o(ser_mode_o), .ser_ctrl_o(ser_ctrl_o),
        .rate_ovr_en_o(rate_ovr_en_o), .rate_ovr_code_o(rate_ovr_code_o),
        .sdio_pulldown_en_o(sdio_pulldown_en_o));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    // ======================================================================
    // Helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Drives one cycle; every signal set once per step, so calls chain
    task automatic cyc(input logic wv, input logic rv, input logic [12:0] a,
                       input logic [7:0] d);
        wr_i = wv;
        rd_i = rv;
        addr_i = a;
        wdata_i = d;
        @(posedge clk_i);
        #1;
    endtask

    task automatic idle(input int n);
        repeat (n) cyc(1'b0, 1'b0, 13'h0000, 8'h00);
    endtask

    task automatic wreg(input logic [12:0] a, input logic [7:0] d);
        cyc(1'b1, 1'b0, a, d);
        idle(2);
    endtask

    task automatic rreg(input logic [12:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        cyc(1'b0, 1'b1, a, 8'h00);
        idle(1);
    endtask

    // Per-channel settings land two edges after the write, as the rest do
    task automatic wadj(input logic [7:0] idx, input logic [7:0] d);
        wreg(ADDR_DEVICE_INDEX, idx);
        cyc(1'b1, 1'b0, ADDR_OUTPUT_ADJUST, d);
        idle(3);
    endtask

    function automatic logic [7:0] rd_exp(input int k, input logic [7:0] d);
        rd_exp = d & RM[k];
        if (RA[k] == ADDR_OUTPUT_MODE) rd_exp = rd_exp | FIXED_OUTPUT_MODE;
        if (RA[k] == ADDR_OUTPUT_PHASE && d[3:0] > OUT_PHASE_MAX) begin
            rd_exp[3:0] = OUT_PHASE_MAX;
        end
    endfunction

    task automatic stop_test;
        $display("mismatches %0d samples_checked %0d", mismatches,
                 samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ======================================================================
    // Read monitor
    always @(posedge clk_i) begin
        if (rvalid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("[ERR] %0t read answer without request", $time);
            end else begin
                check(rdata_o, exp_q.pop_front());
            end
        end
    end

    initial begin
        #20000;
        mismatches++;
        stop_test();
    end

    // ======================================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        #1 arst_n_i = 1'b1;
        check(rst_v, 8'hE0);
        check({4'h0, out_phase_o}, 8'h03);
        check({5'h00, ser_mode_o}, 8'h03);
        for (i = 0; i < 9; i++) begin
            rreg(RA[i], rd_exp(i, RR[i]));
        end
        rreg(13'h000A, 8'h00);
        rreg(ADDR_TRANSFER, 8'h00);
        serial_mode_i = 1'b1;
        idle(4);
        check(8'(dcs_enable_o), 8'h00);
        wreg(ADDR_CLOCK_COND, 8'hFE);
        check(8'(dcs_enable_o), 8'h01);
        wreg(ADDR_CLOCK_COND, 8'h01);
        serial_mode_i = 1'b0;
        idle(4);
        check(8'(dcs_enable_o), 8'h01);
        serial_mode_i = 1'b1;
        idle(4);
        repeat (60) begin
            i = int'($unsigned($random(seed)) % 9);
            w = 8'($random(seed));
            ov = ovr_v[3:0];
            // No clock divider is modelled, so any input phase is legal
            wreg(RA[i], w);
            case (RA[i])
                ADDR_CLOCK_COND:
                    check(8'(dcs_enable_o), 8'(!w[0]));
                ADDR_ENH_CTRL:
                    check(8'(chop_enable_o), 8'(w[2]));
                ADDR_OUTPUT_MODE:
                    check(md_v, {w[6], w[2], w[0], 5'h00});
                ADDR_OUTPUT_PHASE:
                    check(ph_v, rd_exp(i, w));
                ADDR_SERIAL_CTRL: begin
                    check(ser_ctrl_o, w & MASK_SERIAL_CTRL);
                    check({5'h00, ser_mode_o}, {5'h00, w[6:4]});
                end
                ADDR_RATE_OVERRIDE:
                    check(ovr_v, {4'h0, ov});
                ADDR_USER_IO_TWO:
                    check(8'(sdio_pulldown_en_o), 8'(!w[0]));
                default: ;
            endcase
            rreg(RA[i], rd_exp(i, w));
        end
        wreg(ADDR_RATE_OVERRIDE, 8'h46);
        wreg(ADDR_TRANSFER, 8'hFE);
        check(ovr_v, 8'h00);
        wreg(ADDR_TRANSFER, 8'h01);
        check(ovr_v, 8'h0E);
        cyc(1'b1, 1'b0, ADDR_RATE_OVERRIDE, 8'h05);
        wreg(ADDR_TRANSFER, 8'h01);
        check(ovr_v, 8'h05);
        wadj(8'h3F, 8'h00);
        wadj(8'h30, 8'h01);
        check(drv_v, 8'h03);
        wadj(8'h3F, 8'h00);
        wadj(8'h10, 8'h01);
        check(drv_v, 8'h01);
        wadj(8'h3F, 8'h21);
        check(drv_v, 8'hF8);
        wadj(8'h06, 8'h10);
        check(drv_v, 8'h64);
        // Clock outputs left out of the index keep their double drive
        wadj(8'h06, 8'h00);
        check(drv_v, 8'h63);
        idle(4);
        stop_test();
    end
endmodule
